// File: rtl/backup_regs_pkg.sv
// package of constants and carriers for the backup register bank
package backup_regs_pkg;
  localparam int unsigned REG_COUNT = 32;
  localparam int unsigned DATA_WIDTH = 32;
  localparam int unsigned ADDR_WIDTH = 5;
  localparam int unsigned KEY_REGS = 8;
  localparam logic [DATA_WIDTH-1:0] REG_RESET = 32'h00000000;
  localparam logic LOCK_RESET = 1'b0;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_WIDTH-1:0] addr;
    logic [DATA_WIDTH-1:0] wdata;
  } access_t;

  typedef struct packed {
    logic valid;
    logic [DATA_WIDTH-1:0] data;
  } answer_t;
endpackage

// File: rtl/backup_mem.sv
// register-file memory holding the backup words, with erase-all
`timescale 1ns/10ps
module backup_mem #(
  parameter int unsigned DEPTH = 32,
  parameter int unsigned WIDTH = 32,
  parameter int unsigned AW = 5
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic erase,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem [DEPTH];
  initial begin
    if (DEPTH > (1 << AW)) $error("depth exceeds address range");
  end
  // bank sits in the retained domain: only erase or reset clears it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) mem[i] <= backup_regs_pkg::REG_RESET;
      rdata <= backup_regs_pkg::REG_RESET;
    end else begin
      if (erase) begin
        for (int i = 0; i < DEPTH; i++) mem[i] <= backup_regs_pkg::REG_RESET;
      end else if (we) begin
        mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
    end
  end
endmodule

// File: rtl/backup_regs_boot_key_lock.sv
// backup register bank with boot key lock
`timescale 1ns/10ps
module backup_regs_boot_key_lock #(
  parameter int unsigned KEY_REGS = backup_regs_pkg::KEY_REGS
) (
  input wire logic clock,
  input wire logic resetn,
  input wire backup_regs_pkg::access_t access,
  input wire logic lock_write,
  input wire logic lock_wdata,
  input wire logic tamper_event,
  input wire logic readout_protection_disable,
  output backup_regs_pkg::answer_t answer,
  output logic boot_key_lock_bit
);
  initial begin
    if (KEY_REGS > backup_regs_pkg::REG_COUNT) $error("key region larger than bank");
  end

  ////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [1:0] tamper_sync;
    logic [1:0] rdp_sync;
    logic lock;
    logic rd_pend;
    logic rd_blank;
    backup_regs_pkg::answer_t ans;
  } state_t;

  state_t s;
  state_t next_s;
  // kept apart from s: it is reset by the pin, not by its own output
  logic [1:0] rst_sync;
  logic rst_n;
  logic [backup_regs_pkg::DATA_WIDTH-1:0] mem_rdata;
  logic clear_event;
  logic mem_we;

  function automatic logic in_key(input logic [backup_regs_pkg::ADDR_WIDTH-1:0] a);
    return 32'(a) < KEY_REGS;
  endfunction

  ////////////////////////////////////////////////////////////////
  // reset release through two flops
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) rst_sync <= 2'h0;
    else rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  // event pins are asynchronous, only the second flop is used
  assign clear_event = s.tamper_sync[1] | s.rdp_sync[1];
  assign mem_we = access.wr && !(s.lock && in_key(access.addr));

  always_comb begin
    next_s = s;
    next_s.tamper_sync = {s.tamper_sync[0], tamper_event};
    next_s.rdp_sync = {s.rdp_sync[0], readout_protection_disable};
    // clearing wins over a same-cycle set so the erased key stays unlocked
    if (clear_event) begin
      next_s.lock = 1'b0;
    end else if (lock_write && lock_wdata) begin
      next_s.lock = 1'b1;
    end
    next_s.rd_pend = access.rd;
    next_s.rd_blank = s.lock && in_key(access.addr);
    next_s.ans.valid = s.rd_pend;
    next_s.ans.data = (s.rd_blank || clear_event) ? backup_regs_pkg::REG_RESET : mem_rdata;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s.tamper_sync <= 2'h0;
      s.rdp_sync <= 2'h0;
      s.lock <= backup_regs_pkg::LOCK_RESET;
      s.rd_pend <= 1'b0;
      s.rd_blank <= 1'b0;
      s.ans <= '0;
    end else begin
      s.tamper_sync <= next_s.tamper_sync;
      s.rdp_sync <= next_s.rdp_sync;
      s.lock <= next_s.lock;
      s.rd_pend <= next_s.rd_pend;
      s.rd_blank <= next_s.rd_blank;
      s.ans <= next_s.ans;
    end
  end

  backup_mem #(
    .DEPTH(backup_regs_pkg::REG_COUNT),
    .WIDTH(backup_regs_pkg::DATA_WIDTH),
    .AW(backup_regs_pkg::ADDR_WIDTH)
  ) u_mem (
    .clock(clock),
    .rst_n(rst_n),
    .erase(clear_event),
    .we(mem_we),
    .waddr(access.addr),
    .wdata(access.wdata),
    .raddr(access.addr),
    .rdata(mem_rdata)
  );

  assign answer = s.ans;
  assign boot_key_lock_bit = s.lock;

  ////////////////////////////////////////////////////////////////
  sequence lock_set_req;
    lock_write && lock_wdata && !clear_event;
  endsequence

  AST_LOCK_SETS: assert property (@(posedge clock) disable iff (!rst_n)
    lock_set_req |=> boot_key_lock_bit) else $error("lock did not set");
  AST_NO_SW_CLEAR: assert property (@(posedge clock) disable iff (!rst_n)
    boot_key_lock_bit && !clear_event |=> boot_key_lock_bit) else $error("lock cleared by software");
  AST_TAMPER_CLEARS: assert property (@(posedge clock) disable iff (!rst_n)
    s.tamper_sync[1] |=> !boot_key_lock_bit) else $error("tamper did not clear lock");
  AST_RDP_CLEARS: assert property (@(posedge clock) disable iff (!rst_n)
    s.rdp_sync[1] |=> !boot_key_lock_bit) else $error("readout disable did not clear lock");
  AST_LOCKED_READ_ZERO: assert property (@(posedge clock) disable iff (!rst_n)
    access.rd && boot_key_lock_bit && in_key(access.addr) |=> ##1 (answer.valid && answer.data == '0))
    else $error("locked key read not zero");
  AST_READ_LATENCY: assert property (@(posedge clock) disable iff (!rst_n)
    access.rd |=> ##1 answer.valid) else $error("read answer late");
  AST_LOCKED_WRITE_DROP: assert property (@(posedge clock) disable iff (!rst_n)
    access.wr && boot_key_lock_bit && in_key(access.addr) |-> !mem_we) else $error("locked write taken");
  AST_ERASE_ZERO: assert property (@(posedge clock) disable iff (!rst_n)
    clear_event ##1 (access.rd && !clear_event) |=> ##1 (answer.data == '0))
    else $error("bank not erased");
  AST_KEY_UNLOCKED_WRITE: assert property (@(posedge clock) disable iff (!rst_n)
    access.wr && !boot_key_lock_bit && !clear_event |-> mem_we) else $error("unlocked write dropped");

  ////////////////////////////////////////////////////////////////
  // event inputs held three edges reach the lock through both sync flops
  sequence tamper_held;
    tamper_event [*3];
  endsequence

  sequence rdp_held;
    readout_protection_disable [*3];
  endsequence

  sequence locked_key_read;
    access.rd && boot_key_lock_bit && in_key(access.addr);
  endsequence

  sequence open_read;
    access.rd && !in_key(access.addr);
  endsequence

  sequence lone_read;
    access.rd ##1 !access.rd;
  endsequence

  sequence read_then_clear;
    access.rd ##1 clear_event;
  endsequence

  AST_TAMPER_HELD_CLEARS: assert property (@(posedge clock) disable iff (!rst_n)
    tamper_held |=> !boot_key_lock_bit)
    else $error("held tamper left lock set");
  AST_RDP_HELD_CLEARS: assert property (@(posedge clock) disable iff (!rst_n)
    rdp_held |=> !boot_key_lock_bit)
    else $error("held readout disable left lock set");
  AST_LOCKED_READ_ANSWERS: assert property (@(posedge clock) disable iff (!rst_n)
    locked_key_read |=> ##1 answer.valid)
    else $error("locked key read got no answer");
  AST_OPEN_READ_ANSWERS: assert property (@(posedge clock) disable iff (!rst_n)
    open_read |=> ##1 answer.valid)
    else $error("open read got no answer");
  AST_READ_PULSE: assert property (@(posedge clock) disable iff (!rst_n)
    lone_read |=> answer.valid ##1 !answer.valid)
    else $error("answer pulse not one cycle");
  AST_CLEAR_BLANKS_ANSWER: assert property (@(posedge clock) disable iff (!rst_n)
    read_then_clear |=> (answer.valid && answer.data == '0))
    else $error("read during erase not zero");
  AST_NO_SPURIOUS_ANSWER: assert property (@(posedge clock) disable iff (!rst_n)
    !access.rd |=> ##1 !answer.valid)
    else $error("answer without read");
  AST_ANSWER_FROM_READ: assert property (@(posedge clock) disable iff (!rst_n)
    answer.valid |-> $past(access.rd, 2))
    else $error("answer not two cycles after read");
  AST_ZERO_WRITE_IGNORED: assert property (@(posedge clock) disable iff (!rst_n)
    lock_write && !lock_wdata && !boot_key_lock_bit |=> !boot_key_lock_bit)
    else $error("zero write set lock");
  AST_NO_SET_WITHOUT_WRITE: assert property (@(posedge clock) disable iff (!rst_n)
    !boot_key_lock_bit && !lock_write |=> !boot_key_lock_bit)
    else $error("lock set without strobe");
  AST_LOCKED_ZERO_WRITE: assert property (@(posedge clock) disable iff (!rst_n)
    boot_key_lock_bit && lock_write && !lock_wdata && !clear_event |=> boot_key_lock_bit)
    else $error("zero write cleared lock");
  AST_CLEAR_BEATS_SET: assert property (@(posedge clock) disable iff (!rst_n)
    clear_event && lock_write && lock_wdata |=> !boot_key_lock_bit)
    else $error("set won over clear");
  AST_TAMPER_BEATS_SET: assert property (@(posedge clock) disable iff (!rst_n)
    s.tamper_sync[1] && lock_write && lock_wdata |=> !boot_key_lock_bit)
    else $error("set won over tamper");
  AST_RDP_BEATS_SET: assert property (@(posedge clock) disable iff (!rst_n)
    s.rdp_sync[1] && lock_write && lock_wdata |=> !boot_key_lock_bit)
    else $error("set won over readout disable");
  AST_TAMPER_SYNC_FIRST: assert property (@(posedge clock) disable iff (!rst_n)
    tamper_event |=> s.tamper_sync[0])
    else $error("tamper first flop missed");
  AST_TAMPER_SYNC_SECOND: assert property (@(posedge clock) disable iff (!rst_n)
    s.tamper_sync[0] |=> s.tamper_sync[1])
    else $error("tamper second flop missed");
  AST_RDP_SYNC_FIRST: assert property (@(posedge clock) disable iff (!rst_n)
    readout_protection_disable |=> s.rdp_sync[0])
    else $error("readout disable first flop missed");
  AST_RDP_SYNC_SECOND: assert property (@(posedge clock) disable iff (!rst_n)
    s.rdp_sync[0] |=> s.rdp_sync[1])
    else $error("readout disable second flop missed");
  AST_WRITE_NEEDS_STROBE: assert property (@(posedge clock) disable iff (!rst_n)
    mem_we |-> access.wr)
    else $error("write without strobe");
  AST_OPEN_WRITE_TAKEN: assert property (@(posedge clock) disable iff (!rst_n)
    access.wr && !in_key(access.addr) |-> mem_we)
    else $error("open write dropped");
  AST_LOCK_GUARDS_KEY: assert property (@(posedge clock) disable iff (!rst_n)
    boot_key_lock_bit |-> !(mem_we && in_key(access.addr)))
    else $error("key word written while locked");
  AST_CLEAR_ERASES_KEY: assert property (@(posedge clock) disable iff (!rst_n)
    clear_event ##1 (access.rd && in_key(access.addr)) |=> ##1 (answer.data == '0))
    else $error("key word survived erase");
endmodule

// File: tb/backup_regs_boot_key_lock_tb.sv
// self-checking bench for the backup register bank with boot key lock
`timescale 1ns/10ps
module backup_regs_boot_key_lock_tb;
  logic clock;
  logic resetn;
  backup_regs_pkg::access_t access;
  logic lock_write;
  logic lock_wdata;
  logic tamper_event;
  logic rdp_off;
  backup_regs_pkg::answer_t answer;
  logic boot_key_lock_bit;
  int err_count;
  int n_tests;
  logic [31:0] mem [32];
  logic lock;
  backup_regs_boot_key_lock backup_regs_boot_key_lock_i (.clock(clock), .resetn(resetn), .access(access),
    .lock_write(lock_write), .lock_wdata(lock_wdata), .tamper_event(tamper_event),
    .readout_protection_disable(rdp_off), .answer(answer), .boot_key_lock_bit(boot_key_lock_bit));
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // strobe tasks are entered at a rising edge and leave at least one idle edge after
  task automatic wr(input int a, input logic [31:0] d);
    access.wr <= 1'b1;
    access.addr <= a[4:0];
    access.wdata <= d;
    @(posedge clock);
    access.wr <= 1'b0;
    @(posedge clock);
    if (!(lock && a < 8)) mem[a] = d;
  endtask
  task automatic rd(input int a);
    logic seen;
    seen = 1'b0;
    access.rd <= 1'b1;
    access.addr <= a[4:0];
    @(posedge clock);
    access.rd <= 1'b0;
    // answer is a one-cycle pulse, so poll every edge under a bound
    for (int k = 0; k < 5 && !seen; k++) begin
      @(posedge clock);
      #1;
      seen = answer.valid;
    end
    check("answer valid", 32'h1, {31'h0, seen});
    check("read data", (lock && a < 8) ? 32'h0 : mem[a], answer.data);
    @(posedge clock);
  endtask
  task automatic lk(input logic v);
    lock_write <= 1'b1;
    lock_wdata <= v;
    @(posedge clock);
    lock_write <= 1'b0;
    @(posedge clock);
    if (v) lock = 1'b1;
    #1;
    check("lock bit", {31'h0, lock}, {31'h0, boot_key_lock_bit});
    @(posedge clock);
  endtask
  task automatic clr(input int s);
    if (s == 0) tamper_event <= 1'b1;
    else rdp_off <= 1'b1;
    repeat (4) @(posedge clock);
    tamper_event <= 1'b0;
    rdp_off <= 1'b0;
    repeat (4) @(posedge clock);
    lock = 1'b0;
    foreach (mem[i]) mem[i] = 32'h0;
    #1;
    check("lock after clear", 32'h0, {31'h0, boot_key_lock_bit});
    @(posedge clock);
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    err_count++;
    print_verdict();
  end
  initial begin
    void'($urandom(32'hB6513323));
    resetn = 1'b0;
    access = '0;
    lock_write = 1'b0;
    lock_wdata = 1'b0;
    tamper_event = 1'b0;
    rdp_off = 1'b0;
    lock = 1'b0;
    err_count = 0;
    n_tests = 0;
    foreach (mem[i]) mem[i] = 32'h0;
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    repeat (4) @(posedge clock);
    for (int s = 0; s < 2; s++) begin
      for (int i = 0; i < 32; i++) wr(i, $urandom());
      for (int i = 0; i < 32; i++) rd(i);
      lk(1'b0);
      lk(1'b1);
      for (int i = 6; i < 10; i++) wr(i, $urandom());
      for (int i = 0; i < 32; i++) rd(i);
      lk(1'b0);
      clr(s);
      for (int i = 0; i < 32; i++) rd(i);
      $display("test %0d done", s);
    end
    print_verdict();
  end
endmodule
